// file: powerdown_reset_sequencer_bench.sv
// self-checking bench for the power-down and reset sequencer
module powerdown_reset_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, irq;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, rpin, core_ale = 1'b1, core_pss_n = 1'b1;
    logic clk_run, rc_sel, ale, pss_n, core_reset, wake_p, wake_src;
    logic [7:0] port_out, stk_ptr;
    int failures = 0, n_compared = 0, t;
    assign hready = hreadyout;
    // clock at 50 MHz
    always #10 ref_clk = ~ref_clk;
    prs_pins_model pins (.ref_clk(ref_clk), .reset_pin(rpin), .irq_pins(irq));
    prs_sequencer #(.WD_INTERVAL(64), .XTAL_WARM(8)) dut (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_reset_pin(rpin),
        .ext_irq_pin_0(irq[0]), .ext_irq_pin_1(irq[1]), .core_ale(core_ale),
        .core_pss_n(core_pss_n), .clk_run(clk_run), .rc_clk_sel(rc_sel), .ale(ale),
        .program_store_strobe_n(pss_n), .core_reset(core_reset),
        .wake_irq_pulse(wake_p), .wake_irq_src(wake_src), .port_out(port_out),
        .stack_pointer(stk_ptr));
    // compare and count
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one single ahb transfer, waits on hready in both phases
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // wait for core_reset to reach a level, counting cycles
    task wait_cr(input logic lvl, input int lim);
        t = 0;
        while (core_reset !== lvl && t < lim)
        begin
            @(posedge ref_clk);
            t++;
        end
        chk("core_reset level", {31'h0, lvl}, {31'h0, core_reset});
    endtask
    // reset values after power-on
    task t_por;
        wait_cr(1'b0, 40);
        xfer(prs_pkg::ADDR_WDC, 1'b0, 32'h0);
        chk("wdc por", 32'h40, rd);
        chk("port", 32'hFF, {24'h0, port_out});
        chk("stack", 32'h07, {24'h0, stk_ptr});
        chk("hresp", 32'h0, {31'h0, hresp});
        xfer(prs_pkg::ADDR_IEN, 1'b0, 32'h0);
        chk("ien reset", 32'h0, rd);
        xfer(8'h3C, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask
    // watchdog timeout then reset 512 clocks later, held two machine cycles
    task t_wdt;
        int c;
        xfer(prs_pkg::ADDR_WDC, 1'b1, 32'h12);
        c = 0;
        while (core_reset !== 1'b1 && c < 1000)
        begin
            @(posedge ref_clk);
            c++;
        end
        chk("wdt delay ok", 32'h1, {31'h0, c >= 575 && c <= 600});
        wait_cr(1'b0, 20);
        chk("wdt hold", 32'h8, t);
        xfer(prs_pkg::ADDR_WDC, 1'b0, 32'h0);
        chk("wdc wdt", 32'h16, rd);
        xfer(prs_pkg::ADDR_WDC, 1'b1, 32'h02);
    endtask
    // external reset keeps the enable and sets no flag
    task t_ext;
        xfer(prs_pkg::ADDR_PORT, 1'b1, 32'hA5);
        pins.pulse_reset(4);
        wait_cr(1'b1, 40);
        wait_cr(1'b0, 40);
        xfer(prs_pkg::ADDR_WDC, 1'b0, 32'h0);
        chk("wdc ext", 32'h02, rd);
        chk("port ext", 32'hFF, {24'h0, port_out});
    endtask
    // power-down and wake on a level interrupt, rc clock selected
    task t_pd_irq;
        xfer(prs_pkg::ADDR_PORT, 1'b1, 32'h5A);
        xfer(prs_pkg::ADDR_IEN, 1'b1, 32'h1001);
        xfer(prs_pkg::ADDR_EXF, 1'b1, 32'h02);
        chk("ale run", 32'h1, {31'h0, ale});
        xfer(prs_pkg::ADDR_PCTL, 1'b1, 32'h02);
        repeat (3) @(posedge ref_clk);
        chk("clk_run pd", 32'h0, {31'h0, clk_run});
        chk("strobes pd", 32'h0, {30'h0, ale, pss_n});
        chk("port pd", 32'h5A, {24'h0, port_out});
        pins.set_irq(0, 1'b0);
        t = 0;
        while (wake_p !== 1'b1 && t < 50)
        begin
            @(posedge ref_clk);
            t++;
        end
        chk("wake pulse", 32'h1, {31'h0, wake_p});
        chk("wake src", 32'h0, {31'h0, wake_src});
        chk("rc sel", 32'h1, {31'h0, rc_sel});
        pins.set_irq(0, 1'b1);
        repeat (12) @(posedge ref_clk);
        chk("clk_run wake", 32'h1, {31'h0, clk_run});
        chk("rc sel done", 32'h0, {31'h0, rc_sel});
    endtask
    // level wake on pin 1 through the crystal warm-up
    task t_pd_warm;
        xfer(prs_pkg::ADDR_IEN, 1'b1, 32'h1004);
        xfer(prs_pkg::ADDR_PCTL, 1'b1, 32'h02);
        pins.set_irq(1, 1'b0);
        repeat (6) @(posedge ref_clk);
        chk("clk_run warm", 32'h0, {31'h0, clk_run});
        t = 0;
        while (wake_p !== 1'b1 && t < 50)
        begin
            @(posedge ref_clk);
            t++;
        end
        chk("wake pulse 1", 32'h1, {31'h0, wake_p});
        chk("wake src 1", 32'h1, {31'h0, wake_src});
        chk("rc sel 1", 32'h0, {31'h0, rc_sel});
        pins.set_irq(1, 1'b1);
    endtask
    // edge mode cannot wake; reset pin ends power-down
    task t_pd_edge;
        xfer(prs_pkg::ADDR_IEN, 1'b1, 32'h3001);
        xfer(prs_pkg::ADDR_PCTL, 1'b1, 32'h02);
        pins.set_irq(0, 1'b0);
        repeat (40) @(posedge ref_clk);
        chk("edge no wake", 32'h0, {31'h0, clk_run});
        pins.set_irq(0, 1'b1);
        pins.pulse_reset(4);
        wait_cr(1'b1, 200);
        wait_cr(1'b0, 200);
        chk("run after", 32'h1, {31'h0, clk_run});
        chk("stack after", 32'h07, {24'h0, stk_ptr});
    endtask
    // verdict and end of run
    task print_verdict;
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_por();
        t_wdt();
        t_ext();
        t_pd_irq();
        t_pd_edge();
        t_pd_warm();
        print_verdict();
    end
    // hang guard
    initial
    begin
        #400000;
        failures++;
        print_verdict();
    end
endmodule

// file: prs_pins_model.sv
// partner model: external reset pin and the two external interrupt pins
module prs_pins_model (
    input  wire logic ref_clk,   // system clock
    output logic      reset_pin, // external reset, pulled down when idle
    output logic [1:0] irq_pins  // interrupt pins, pulled up when idle
);
    timeunit 1ns;
    timeprecision 1ns;
    // pins start released: reset low, interrupts high
    initial
    begin
        reset_pin = 1'b0;
        irq_pins  = 2'h3;
    end
    // reset held for whole machine cycles, never fewer than two
    task pulse_reset(input int mc);
        int n;
        n = (mc < 2) ? 2 : mc;
        @(posedge ref_clk);
        reset_pin <= 1'b1;
        repeat (4 * n) @(posedge ref_clk);
        reset_pin <= 1'b0;
    endtask
    // drive one interrupt pin low or release it high
    task set_irq(input int idx, input logic lvl);
        irq_pins[idx] <= lvl;
    endtask
endmodule

// file: prs_pkg.sv
// constants and types for the power-down and reset sequencer
package prs_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_PCTL = 8'h00;
    localparam logic [7:0] ADDR_WDC  = 8'h04;
    localparam logic [7:0] ADDR_EXF  = 8'h08;
    localparam logic [7:0] ADDR_IEN  = 8'h0C;
    localparam logic [7:0] ADDR_PORT = 8'h10;
    localparam logic [7:0] ADDR_STK  = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;
    // power_control_reg fields
    localparam int PCTL_IDLE = 0;
    localparam int PCTL_PD   = 1;
    // watchdog_control fields
    localparam int WDC_CLR  = 0;
    localparam int WDC_RSTEN = 1;
    localparam int WDC_RSTFL = 2;
    localparam int WDC_FLAG = 3;
    localparam int WDC_RUN  = 4;
    localparam int WDC_POR  = 6;
    localparam logic [7:0] WDC_POR_VAL  = 8'h40;
    localparam logic [7:0] WDC_EXT_KEEP = 8'h56;
    localparam logic [7:0] WDC_WDT_KEEP = 8'h52;
    localparam logic [7:0] WDC_WDT_SET  = 8'h04;
    localparam logic [7:0] WDC_WR_MASK  = 8'h5E;
    // ext_irq_flag_reg fields
    localparam int EXF_RCNOW = 0;
    localparam int EXF_RCSEL = 1;
    localparam logic [7:0] EXF_WR_MASK = 8'h02;
    // interrupt enable register fields
    localparam int IEN_W    = 15;
    localparam int IEN_PIN0 = 0;
    localparam int IEN_PIN1 = 2;
    localparam int IEN_GLB  = 12;
    localparam int IEN_TS0  = 13;
    localparam int IEN_TS1  = 14;
    // reset values and timing
    localparam logic [7:0] PORT_RST    = 8'hFF;
    localparam logic [7:0] STK_RST     = 8'h07;
    localparam logic [1:0] C4_PHASE    = 2'h3;
    localparam logic [1:0] RST_TAIL_MC = 2'h2;
    localparam logic [1:0] WDT_HOLD_MC = 2'h2;
    localparam int         WD_RST_CLKS = 512;
    localparam int         WDR_W       = 10;
    localparam int         WD_CNT_W    = 18;
    localparam int         WARM_W      = 12;

    typedef enum logic [1:0] {ST_RUN, ST_PDOWN, ST_WARM, ST_RESET} prs_state_type;

    typedef struct packed {
        prs_state_type         st;
        logic [1:0]            phase;
        logic                  rst_meta;
        logic                  rst_s;
        logic [1:0]            irq_meta;
        logic [1:0]            irq_s;
        logic [1:0]            rst_hist;
        logic [1:0]            hold;
        logic                  wake_rst;
        logic                  wake_src;
        logic [WARM_W-1:0]     warm;
        logic                  warming;
        logic [WD_CNT_W-1:0]   wd_cnt;
        logic                  wd_arm;
        logic [WDR_W-1:0]      wdr_cnt;
        logic [7:0]            pctl;
        logic [7:0]            wdc;
        logic [7:0]            exf;
        logic [IEN_W-1:0]      ien;
        logic [7:0]            port;
        logic [7:0]            stk;
        logic                  dp_wr;
        logic [7:0]            dp_addr;
        logic [31:0]           hrdata;
        logic                  hready;
        logic                  clk_run;
        logic                  ale;
        logic                  pss_n;
        logic                  core_reset;
        logic                  wake_pulse;
    } prs_regs_type;
endpackage

// file: prs_sequencer.sv
// power-down entry, wake-up and reset sequencing with an ahb-lite register slave
// Behaviour
// [RULE1] writing one to the power-down bit halts all clocks after that write
// [RULE2] while powered down, ale and program store strobe low, ports hold value
// [RULE3] reset pin high in power-down restarts clock, then runs from address zero
// [RULE4] watchdog is frozen in power-down and cannot cause the exit
// [RULE5] level-mode enabled external interrupt with global enable wakes on low pin
// [RULE6] interrupt wake signals the core to service it, then resume after entry
// [RULE7] rc wake-select leaves power-down on rc clock, crystal taken once stable
// [RULE8] reset pin sampled at C4 each machine cycle; source holds two cycles
// [RULE9] internal reset applied synchronously, only while the clock runs
// [RULE10] reset lasts while pin high plus two machine cycles, then address zero
// [RULE11] external reset sets no cause flag; both flags clear means external
// [RULE12] watchdog free-runs, clear restarts, timeout flags, reset 512 clocks later
// [RULE13] watchdog reset held two machine cycles, then execution from zero
// [RULE14] reset holds program counter zero, stack pointer 07h, ram untouched
// [RULE15] reset clears control registers and loads ports with all ones
// [RULE16] watchdog disabled after reset only when the source was power-on
// [RULE17] watchdog control reset value depends on the reset source
// [RULE18] power-on flag in bit 6 set only by power-on reset; here a bus write to watchdog_control can also set it
// [RULE19] watchdog-reset flag in bit 2 set by watchdog reset, cleared by power-on
// [RULE20] watchdog-reset enable bit 1 cleared by power-on, kept by other resets
// [RULE21] twelve interrupt enables plus a global enable
// [RULE22] trigger select of external interrupts 0 and 1; only level mode wakes
// [RULE23] external interrupts two to five are edge only and never wake
// [RULE24] reset beats an interrupt wake arriving in the same cycle
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
module prs_sequencer #(
    parameter int WD_INTERVAL = 131072,     // watchdog timeout in clocks
    parameter int XTAL_WARM   = 1024        // crystal warm-up in clocks
) (
    input  wire logic        ref_clk,        // system oscillator clock
    input  wire logic        rst,            // power-on reset, async high
    input  wire logic        hsel,           // ahb slave select
    input  wire logic [31:0] haddr,          // ahb address
    input  wire logic [1:0]  htrans,         // ahb transfer type
    input  wire logic        hwrite,         // ahb write
    input  wire logic [2:0]  hsize,          // ahb size, word only
    input  wire logic [31:0] hwdata,         // ahb write data
    input  wire logic        hready,         // ahb bus ready
    output logic             hreadyout,      // ahb ready out
    output logic             hresp,          // ahb response, okay
    output logic [31:0]      hrdata,         // ahb read data
    input  wire logic        ext_reset_pin,  // external reset pin, high
    input  wire logic        ext_irq_pin_0,  // external interrupt pin 0
    input  wire logic        ext_irq_pin_1,  // external interrupt pin 1
    input  wire logic        core_ale,       // ale from the core
    input  wire logic        core_pss_n,     // program store strobe from core
    output logic             clk_run,        // core clock enable
    output logic             rc_clk_sel,     // core runs on rc oscillator
    output logic             ale,            // address latch strobe pin
    output logic             program_store_strobe_n, // program store strobe pin
    output logic             core_reset,     // core reset, pc held at zero
    output logic             wake_irq_pulse, // interrupt wake to core
    output logic             wake_irq_src,   // which pin woke the core
    output logic [7:0]       port_out,       // port pin levels
    output logic [7:0]       stack_pointer   // stack pointer value
);
    prs_pkg::prs_regs_type q;
    prs_pkg::prs_regs_type d;
    logic c4;
    logic ext_det;
    logic wake_ok;
    logic wr;
    logic pd_req;
    logic wd_clr;
    logic wdt_fire;
    logic enter_rst;
    logic rst_is_wdt;

    // next-state logic
    always_comb
    begin
        d = q;
        c4 = 1'b0;
        ext_det = 1'b0;
        wake_ok = 1'b0;
        wr = 1'b0;
        pd_req = 1'b0;
        wd_clr = 1'b0;
        wdt_fire = 1'b0;
        enter_rst = 1'b0;
        rst_is_wdt = 1'b0;
        d.wake_pulse = 1'b0;
        // pin synchronisers
        d.rst_meta = ext_reset_pin;
        d.rst_s = q.rst_meta;
        d.irq_meta = {ext_irq_pin_1, ext_irq_pin_0};
        d.irq_s = q.irq_meta;

        // machine-cycle phase, frozen while clocks are stopped
        if (q.st == prs_pkg::ST_RUN || q.st == prs_pkg::ST_RESET)
        begin
            d.phase = q.phase + 2'h1;
            c4 = (q.phase == prs_pkg::C4_PHASE);
        end
        // two C4 samples high make a valid external reset
        if (c4)
        begin
            d.rst_hist = {q.rst_hist[0], q.rst_s}; // [RULE8]
        end
        ext_det = c4 && q.rst_hist[0] && q.rst_s && q.st == prs_pkg::ST_RUN; // [RULE8] [RULE9]

        // wake qualification, level mode only; ints 2..5 never qualify
        wake_ok = q.ien[prs_pkg::IEN_GLB] &&
                  ((q.ien[prs_pkg::IEN_PIN0] && !q.ien[prs_pkg::IEN_TS0] && !q.irq_s[0]) ||
                   (q.ien[prs_pkg::IEN_PIN1] && !q.ien[prs_pkg::IEN_TS1] && !q.irq_s[1]));
        // [RULE5] [RULE22] [RULE23] [RULE21]

        // bus writes land in the data phase; ignored while the core is stopped
        wr = q.dp_wr && q.st == prs_pkg::ST_RUN;
        if (wr)
        begin
            unique case (q.dp_addr)
                prs_pkg::ADDR_PCTL:
                begin
                    d.pctl = hwdata[7:0];
                    pd_req = hwdata[prs_pkg::PCTL_PD]; // [RULE1]
                end
                prs_pkg::ADDR_WDC:
                begin
                    d.wdc = (q.wdc & ~prs_pkg::WDC_WR_MASK) |
                            (hwdata[7:0] & prs_pkg::WDC_WR_MASK);
                    wd_clr = hwdata[prs_pkg::WDC_CLR];
                end
                prs_pkg::ADDR_EXF:
                begin
                    d.exf = (q.exf & ~prs_pkg::EXF_WR_MASK) |
                            (hwdata[7:0] & prs_pkg::EXF_WR_MASK);
                end
                prs_pkg::ADDR_IEN:  d.ien = hwdata[prs_pkg::IEN_W-1:0]; // [RULE21]
                prs_pkg::ADDR_PORT: d.port = hwdata[7:0];
                prs_pkg::ADDR_STK:  d.stk = hwdata[7:0];
                default:            d.pctl = q.pctl;
            endcase
        end

        // watchdog: free running, stopped outside run state
        if (wd_clr)
        begin
            d.wd_cnt = '0; // [RULE12]
            d.wd_arm = 1'b0;
            d.wdr_cnt = '0;
        end
        else if (q.st == prs_pkg::ST_RUN && q.wdc[prs_pkg::WDC_RUN]) // [RULE4]
        begin
            if (q.wd_cnt == prs_pkg::WD_CNT_W'(WD_INTERVAL - 1))
            begin
                d.wd_cnt = '0;
                d.wdc[prs_pkg::WDC_FLAG] = 1'b1; // set beats a clearing write [RULE12]
                d.wd_arm = 1'b1;
            end
            else
            begin
                d.wd_cnt = q.wd_cnt + prs_pkg::WD_CNT_W'(1);
            end
            if (q.wd_arm)
            begin
                d.wdr_cnt = q.wdr_cnt + prs_pkg::WDR_W'(1);
                wdt_fire = q.wdc[prs_pkg::WDC_RSTEN] &&
                    q.wdr_cnt == prs_pkg::WDR_W'(prs_pkg::WD_RST_CLKS - 1); // [RULE12]
            end
        end

        // sequencing
        unique case (q.st)
            prs_pkg::ST_RUN:
            begin
                if (ext_det || wdt_fire)
                begin
                    enter_rst = 1'b1;
                    rst_is_wdt = wdt_fire && !ext_det;
                end
                else if (pd_req)
                begin
                    d.st = prs_pkg::ST_PDOWN; // [RULE1]
                end
                // rc clock until the crystal is stable
                if (q.warming)
                begin
                    d.warm = q.warm + prs_pkg::WARM_W'(1);
                    if (q.warm == prs_pkg::WARM_W'(XTAL_WARM - 1))
                    begin
                        d.warming = 1'b0;
                        d.exf[prs_pkg::EXF_RCNOW] = 1'b0; // [RULE7]
                    end
                end
            end
            prs_pkg::ST_PDOWN:
            begin
                d.warm = '0;
                if (q.rst_s)
                begin
                    d.st = prs_pkg::ST_WARM; // [RULE3] [RULE24]
                    d.wake_rst = 1'b1;
                end
                else if (wake_ok)
                begin
                    d.wake_rst = 1'b0;
                    d.wake_src = !(q.ien[prs_pkg::IEN_PIN0] && !q.ien[prs_pkg::IEN_TS0] &&
                                   !q.irq_s[0]);
                    d.pctl[prs_pkg::PCTL_PD] = 1'b0;
                    if (q.exf[prs_pkg::EXF_RCSEL])
                    begin
                        d.st = prs_pkg::ST_RUN; // [RULE7]
                        d.warming = 1'b1;
                        d.exf[prs_pkg::EXF_RCNOW] = 1'b1;
                        d.wake_pulse = 1'b1; // [RULE6]
                    end
                    else
                    begin
                        d.st = prs_pkg::ST_WARM;
                    end
                end
            end
            prs_pkg::ST_WARM:
            begin
                if (q.rst_s)
                begin
                    d.wake_rst = 1'b1; // [RULE24]
                end
                d.warm = q.warm + prs_pkg::WARM_W'(1);
                if (q.warm == prs_pkg::WARM_W'(XTAL_WARM - 1))
                begin
                    if (q.wake_rst || q.rst_s)
                    begin
                        enter_rst = 1'b1; // [RULE3]
                    end
                    else
                    begin
                        d.st = prs_pkg::ST_RUN;
                        d.wake_pulse = 1'b1; // [RULE6]
                    end
                end
            end
            prs_pkg::ST_RESET:
            begin
                // held while the pin is high, then two more machine cycles
                if (c4)
                begin
                    if (q.rst_s)
                    begin
                        d.hold = prs_pkg::RST_TAIL_MC; // [RULE10]
                    end
                    else if (q.hold == 2'h1)
                    begin
                        d.st = prs_pkg::ST_RUN; // [RULE10] [RULE13]
                        d.hold = 2'h0;
                    end
                    else
                    begin
                        d.hold = q.hold - 2'h1;
                    end
                end
            end
        endcase

        // synchronous reset entry and source-dependent flags
        if (enter_rst)
        begin
            d.st = prs_pkg::ST_RESET; // [RULE9]
            d.phase = 2'h0;
            d.hold = rst_is_wdt ? prs_pkg::WDT_HOLD_MC : prs_pkg::RST_TAIL_MC; // [RULE13]
            d.rst_hist = 2'h0;
            d.wake_rst = 1'b0;
            d.warming = 1'b0;
            d.wd_cnt = '0;
            d.wd_arm = 1'b0;
            d.wdr_cnt = '0;
            if (rst_is_wdt)
            begin
                d.wdc = (q.wdc & prs_pkg::WDC_WDT_KEEP) | prs_pkg::WDC_WDT_SET; // [RULE17] [RULE19]
            end
            else
            begin
                d.wdc = q.wdc & prs_pkg::WDC_EXT_KEEP; // [RULE11] [RULE17] [RULE20]
            end
        end
        // registers held at reset values throughout reset
        if (d.st == prs_pkg::ST_RESET)
        begin
            d.pctl = '0; // [RULE15]
            d.exf = '0;
            d.ien = '0;
            d.port = prs_pkg::PORT_RST; // [RULE15]
            d.stk = prs_pkg::STK_RST; // [RULE14]
        end

        // ahb address phase, read data from post-write values
        d.dp_wr = hsel && htrans[1] && hready && hwrite;
        d.dp_addr = haddr[7:0];
        if (hsel && htrans[1] && hready && !hwrite)
        begin
            unique case (haddr[7:0])
                prs_pkg::ADDR_PCTL: d.hrdata = {24'h0, d.pctl};
                prs_pkg::ADDR_WDC:  d.hrdata = {24'h0, d.wdc};
                prs_pkg::ADDR_EXF:  d.hrdata = {24'h0, d.exf};
                prs_pkg::ADDR_IEN:  d.hrdata = {17'h0, d.ien};
                prs_pkg::ADDR_PORT: d.hrdata = {24'h0, d.port};
                prs_pkg::ADDR_STK:  d.hrdata = {24'h0, d.stk};
                prs_pkg::ADDR_STAT: d.hrdata = {28'h0, d.st, q.wd_arm, q.warming};
                default:            d.hrdata = 32'h0;
            endcase
        end
        d.hready = 1'b1;

        // registered pin and core controls
        d.clk_run = (d.st == prs_pkg::ST_RUN || d.st == prs_pkg::ST_RESET); // [RULE1]
        d.core_reset = (d.st == prs_pkg::ST_RESET); // [RULE14]
        d.ale = d.clk_run ? core_ale : 1'b0; // [RULE2]
        d.pss_n = d.clk_run ? core_pss_n : 1'b0; // [RULE2]
    end

    // state register; power-on reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
            q.st <= prs_pkg::ST_RESET;
            q.hold <= prs_pkg::RST_TAIL_MC;
            q.wdc <= prs_pkg::WDC_POR_VAL; // [RULE16] [RULE18] [RULE19] [RULE20]
            q.port <= prs_pkg::PORT_RST;
            q.stk <= prs_pkg::STK_RST;
            q.hready <= 1'b1;
            q.clk_run <= 1'b1;
            q.core_reset <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from the state register, hresp tied to okay
    assign hreadyout = q.hready;
    assign hresp = 1'b0;
    assign hrdata = q.hrdata;
    assign clk_run = q.clk_run;
    assign rc_clk_sel = q.exf[prs_pkg::EXF_RCNOW];
    assign ale = q.ale;
    assign program_store_strobe_n = q.pss_n;
    assign core_reset = q.core_reset;
    assign wake_irq_pulse = q.wake_pulse;
    assign wake_irq_src = q.wake_src;
    assign port_out = q.port; // [RULE2]
    assign stack_pointer = q.stk;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_wdt_entry;
        q.st == prs_pkg::ST_RUN && wdt_fire && !ext_det;
    endsequence

    AST_PD_ENTRY: assert property (pd_req && q.st == prs_pkg::ST_RUN && !enter_rst // [RULE1]
        |=> q.st == prs_pkg::ST_PDOWN ##0 !clk_run)
        else $error("power-down not entered after write");
    AST_PD_PINS: assert property (q.st == prs_pkg::ST_PDOWN // [RULE2]
        |-> !ale && !program_store_strobe_n && $stable(port_out))
        else $error("strobes not low in power-down");
    AST_PD_RST_WAKE: assert property (q.st == prs_pkg::ST_PDOWN && q.rst_s // [RULE3]
        |=> q.st == prs_pkg::ST_WARM && q.wake_rst)
        else $error("reset pin did not end power-down");
    AST_WD_FROZEN: assert property (q.st == prs_pkg::ST_PDOWN |=> $stable(q.wd_cnt)) // [RULE4]
        else $error("watchdog moved in power-down");
    AST_NO_WAKE: assert property (q.st == prs_pkg::ST_PDOWN && !q.rst_s && !wake_ok // [RULE5]
        |=> q.st == prs_pkg::ST_PDOWN)
        else $error("power-down left without cause");
    AST_RST_HELD: assert property (q.st == prs_pkg::ST_RESET && c4 && q.rst_s // [RULE10]
        |=> q.st == prs_pkg::ST_RESET [*4])
        else $error("reset released while pin high");
    AST_WDT_HOLD: assert property (s_wdt_entry |=> core_reset [*8] ##1 !core_reset) // [RULE13]
        else $error("watchdog reset not two machine cycles");
    AST_WDT_FLAGS: assert property (s_wdt_entry // [RULE17]
        |=> q.wdc[prs_pkg::WDC_RSTFL] && !q.wdc[prs_pkg::WDC_FLAG] &&
            q.wdc[prs_pkg::WDC_POR] == $past(q.wdc[prs_pkg::WDC_POR]) &&
            q.wdc[prs_pkg::WDC_RSTEN] == $past(q.wdc[prs_pkg::WDC_RSTEN]))
        else $error("watchdog reset flags wrong");
    AST_RST_STK: assert property (core_reset // [RULE14]
        |-> stack_pointer == prs_pkg::STK_RST && port_out == prs_pkg::PORT_RST)
        else $error("reset values not held");
    AST_RST_PRIO: assert property (q.st == prs_pkg::ST_PDOWN && q.rst_s && wake_ok // [RULE24]
        |=> !wake_irq_pulse && q.wake_rst)
        else $error("interrupt beat reset");
endmodule
